// >>> dv/sfes_chk.sv
// Concurrent checks on the erase sequencer outputs in the link clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfes_chk (
   input wire logic rstn,
   input wire logic sck,
   input wire logic uniform_large_sectors,
   input wire logic target_protected,
   input wire logic range_has_protected,
   input wire logic [2:0] block_protect_bits,
   input wire logic work_in_progress_flag,
   input wire logic erase_suspended,
   input wire logic erase_error,
   input wire logic erase_start,
   input wire logic [31:0] erase_len
);
   default clocking cb @(posedge sck); endclocking
   default disable iff (!rstn);
   sequence s_start;
      erase_start ##1 !erase_start;
   endsequence
   sequence s_busy;
      ##[0:2] work_in_progress_flag;
   endsequence
   chk_start_one_pulse: assert property (erase_start |-> s_start) else $error("start pulse too long");
   chk_start_sets_busy: assert property (s_start |-> s_busy) else $error("busy not set");
   chk_suspend_idle: assert property (erase_suspended |-> !work_in_progress_flag) else $error("busy when held");
   chk_error_cause: assert property ($rose(erase_error) |-> target_protected || range_has_protected
      || block_protect_bits != 3'h0) else $error("error without cause");
   chk_error_no_start: assert property ($rose(erase_error) |-> !erase_start) else $error("start with error");
   chk_uniform_small: assert property (erase_start && uniform_large_sectors |-> erase_len != 32'h1000)
      else $error("small erase ran");
   chk_range_guard: assert property (erase_start && erase_len <= 32'h40000 |-> !range_has_protected
      && !target_protected) else $error("guarded range ran");
   chk_suspend_no_start: assert property ($rose(erase_suspended) |-> !erase_start) else $error("start at hold");
endmodule : sfes_chk
`default_nettype wire

// >>> dv/tb_serial_flash_erase_sequencer.sv
// Self-checking bench joining the host and the erase sequencer over the link.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_erase_sequencer;
   import sfes_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic extended_address_setting = 1'b0;
   logic uniform_large_sectors = 1'b0;
   logic sector_size_256k = 1'b0;
   logic [2:0] block_protect_bits = 3'h0;
   logic target_protected = 1'b0;
   logic range_has_protected = 1'b0;
   logic target_is_small = 1'b1;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_op = 8'h00;
   logic [31:0] cmd_addr = 32'h0;
   logic [5:0] cmd_addr_bits = 6'h0;
   logic cmd_busy, status_valid, work_in_progress_flag, erase_suspended, erase_error, erase_start;
   logic [7:0] status_byte, last_st;
   logic [31:0] erase_addr, erase_len;
   logic [15:0] st_q[$];
   logic [32:0] len_q[$];
   logic [7:0] t_op[9] = '{OP_SE, OP_SE_WIDE, OP_SE, OP_PSE, OP_PSE_WIDE, OP_PSE, OP_SE_WIDE, OP_WAE_A, OP_WAE_B};
   logic [5:0] t_bits[9] = '{6'h18, 6'h20, 6'h18, 6'h18, 6'h20, 6'h20, 6'h20, 6'h0, 6'h0};
   logic [1:0] t_cfg[9] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
   logic [32:0] t_len[9] = '{33'h100010000, 33'h100010000, 33'h100040000, 33'h100001000, 33'h100001000,
      33'h100001000, 33'h100040000, 33'h0, 33'h0};
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 45740;
   sfes_link_if sfes_link_if_inst ();
   sfes_host #(.DIV(HOST_DIV)) sfes_host_inst (.clk, .rstn, .link(sfes_link_if_inst), .cmd_valid, .cmd_op,
      .cmd_addr, .cmd_addr_bits, .cmd_busy, .status_byte, .status_valid);
   sfes_device #(.PSE_CYC(16), .SE_CYC(64), .WAE_CYC(64), .SUS_CYC(4)) sfes_device_inst (.rstn,
      .link(sfes_link_if_inst), .extended_address_setting, .uniform_large_sectors, .sector_size_256k,
      .block_protect_bits, .target_protected, .range_has_protected, .target_is_small, .work_in_progress_flag,
      .erase_suspended, .erase_error, .erase_start, .erase_addr, .erase_len);
   sfes_chk sfes_chk_inst (.rstn, .sck(sfes_link_if_inst.sck), .uniform_large_sectors, .target_protected,
      .range_has_protected, .block_protect_bits, .work_in_progress_flag, .erase_suspended, .erase_error,
      .erase_start, .erase_len);
   always #25 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   task automatic send(input logic [7:0] op, input logic [5:0] bits);
      int i;
      @(posedge clk);
      #2;
      cmd_op = op;
      cmd_addr = $random(seed);
      cmd_addr_bits = bits;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      for (i = 0; i < 2000 && cmd_busy !== 1'b0; i++) begin
         @(posedge clk);
         #2;
      end
      if (i >= 2000) n_errors++;
   endtask : send
   task automatic rd(input logic [7:0] op, input logic [15:0] mv);
      st_q.push_back(mv);
      send(op, 6'h0);
      @(posedge clk);
      #2;
   endtask : rd
   task automatic idle;
      int k;
      for (k = 0; k < 60; k++) begin
         rd(OP_STATUS_ONE, 16'h0);
         if (last_st[SR1_WIP] === 1'b0) break;
      end
      check(32'(last_st[SR1_WIP]), 32'h0);
   endtask : idle
   always @(posedge clk) begin
      if (status_valid === 1'b1) begin
         last_st <= status_byte;
         if (st_q.size() == 0) check(32'h1, 32'h0);
         else check(32'(status_byte & st_q[0][15:8]), 32'(st_q[0][7:0]));
         if (st_q.size() != 0) void'(st_q.pop_front());
      end
   end
   always @(posedge sfes_link_if_inst.sck) begin
      if (erase_start === 1'b1) begin
         if (len_q.size() == 0) check(32'h1, 32'h0);
         else if (len_q[0][32]) check(erase_len, len_q[0][31:0]);
         if (len_q.size() != 0) void'(len_q.pop_front());
      end
   end
   initial begin
      #4000000;
      n_errors++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk);
      #2;
      rstn = 1'b1;
      send(OP_SE, 6'h18);
      rd(OP_STATUS_ONE, 16'h2300);
      send(OP_WRITE_ENABLE, 6'h0);
      rd(OP_STATUS_ONE, 16'h0302);
      send(OP_SE, 6'h0);
      rd(OP_STATUS_ONE, 16'h0100);
      for (int i = 0; i < 9; i++) begin
         sector_size_256k = t_cfg[i][1];
         extended_address_setting = t_cfg[i][0];
         send(OP_WRITE_ENABLE, 6'h0);
         len_q.push_back(t_len[i]);
         send(t_op[i], t_bits[i]);
         rd(OP_STATUS_ONE, 16'h0101);
         idle();
      end
      sector_size_256k = 1'b0;
      extended_address_setting = 1'b0;
      for (int i = 0; i < 3; i++) begin
         uniform_large_sectors = (i == 0);
         target_is_small = (i != 1);
         block_protect_bits = (i == 2) ? (3'($random(seed)) | 3'h1) : 3'h0;
         send(OP_WRITE_ENABLE, 6'h0);
         send(i == 2 ? OP_WAE_A : OP_PSE, 6'(i == 2 ? 0 : 24));
         rd(OP_STATUS_ONE, 16'h2100);
      end
      block_protect_bits = 3'h0;
      target_is_small = 1'b1;
      send(OP_WRITE_ENABLE, 6'h0);
      len_q.push_back(33'h100010000);
      send(OP_SE, 6'h18);
      send(OP_SUSPEND, 6'h0);
      idle();
      rd(OP_STATUS_TWO, 16'h0202);
      send(OP_RESUME, 6'h0);
      rd(OP_STATUS_ONE, 16'h0101);
      rd(OP_STATUS_TWO, 16'h0200);
      send(OP_RESUME, 6'h0);
      idle();
      rd(OP_STATUS_TWO, 16'h0200);
      send(OP_WRITE_ENABLE, 6'h0);
      len_q.push_back(33'h0);
      send(OP_WAE_B, 6'h0);
      send(OP_SUSPEND, 6'h0);
      rd(OP_STATUS_TWO, 16'h0200);
      rd(OP_STATUS_ONE, 16'h0101);
      idle();
      range_has_protected = 1'b1;
      send(OP_WRITE_ENABLE, 6'h0);
      send(OP_SE, 6'h18);
      rd(OP_STATUS_ONE, 16'h2120);
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      rstn = 1'b1;
      range_has_protected = 1'b0;
      target_protected = 1'b1;
      send(OP_WRITE_ENABLE, 6'h0);
      send(OP_PSE, 6'h18);
      rd(OP_STATUS_ONE, 16'h2120);
      check(32'(len_q.size() + st_q.size()), 32'h0);
      results();
   end
endmodule : tb_serial_flash_erase_sequencer
`default_nettype wire

// >>> verilog/sfes_device.sv
// Flash erase command sequencer, clocked by the serial link clock.
`timescale 1ns/1ps
`default_nettype none
module sfes_device #(
   parameter int PSE_CYC = sfes_pkg::PSE_CYCLES,
   parameter int SE_CYC = sfes_pkg::SE_CYCLES,
   parameter int WAE_CYC = sfes_pkg::WAE_CYCLES,
   parameter int SUS_CYC = sfes_pkg::SUSPEND_CYCLES
) (
   input wire logic rstn,
   sfes_link_if.dev link,
   input wire logic extended_address_setting,
   input wire logic uniform_large_sectors,
   input wire logic sector_size_256k,
   input wire logic [2:0] block_protect_bits,
   input wire logic target_protected,
   input wire logic range_has_protected,
   input wire logic target_is_small,
   output logic work_in_progress_flag,
   output logic erase_suspended,
   output logic erase_error,
   output logic erase_start,
   output logic [31:0] erase_addr,
   output logic [31:0] erase_len
);
   import sfes_pkg::*;
   typedef enum logic [3:0] {
      SFES_IDLE = 4'b0001,
      SFES_RUN = 4'b0010,
      SFES_SUSPENDING = 4'b0100,
      SFES_SUSPENDED = 4'b1000
   } sfes_state_t;
   sfes_state_t state_q;
   logic [5:0] bit_cnt_q;
   logic [7:0] op_q;
   logic [31:0] addr_q;
   logic [31:0] timer_q;
   logic [31:0] erase_cyc_q;
   logic wel_q;
   logic is_wae_q;
   logic [7:0] op_now;
   logic [5:0] addr_bits;
   logic is_pse;
   logic is_se;
   logic frame_done;
   logic [7:0] status_q;
   logic [31:0] sus_cnt_q;
   logic frame_tgl_q;
   logic tgl_seen_q;
   logic [7:0] done_op_q;
   logic [5:0] done_bits_q;
   assign op_now = {op_q[6:0], link.si};
   assign is_pse = (done_op_q == OP_PSE) || (done_op_q == OP_PSE_WIDE);
   assign is_se = (done_op_q == OP_SE) || (done_op_q == OP_SE_WIDE);
   assign addr_bits = (extended_address_setting || done_op_q == OP_PSE_WIDE || done_op_q == OP_SE_WIDE)
      ? 6'(ADDR4_BITS) : 6'(ADDR3_BITS);
   // Shift in opcode and address bits on rising sck; the first edge of a frame restarts the count.
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q <= 6'h0;
         op_q <= 8'h0;
         addr_q <= 32'h0;
      end else begin
         if (frame_done || bit_cnt_q < 6'(OP_BITS)) begin
            op_q <= op_now;
         end else begin
            addr_q <= {addr_q[30:0], link.si};
         end
         if (frame_done) begin
            bit_cnt_q <= 6'h1;
         end else if (bit_cnt_q != 6'h3f) begin
            bit_cnt_q <= bit_cnt_q + 6'h1;
         end
      end
   end
   // Chip-select release closes a frame while sck is parked, so the frame is captured on that edge.
   always_ff @(posedge link.cs_n or negedge rstn) begin
      if (!rstn) begin
         frame_tgl_q <= 1'b0;
         done_op_q <= 8'h0;
         done_bits_q <= 6'h0;
      end else begin
         frame_tgl_q <= ~frame_tgl_q;
         done_op_q <= op_q;
         done_bits_q <= bit_cnt_q;
      end
   end
   // The captured frame is acted on at the next sck edge.
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         tgl_seen_q <= 1'b0;
      end else begin
         tgl_seen_q <= frame_tgl_q;
      end
   end
   assign frame_done = frame_tgl_q != tgl_seen_q;
   // Command execution and erase timing.
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         state_q <= SFES_IDLE;
         timer_q <= 32'h0;
         erase_cyc_q <= 32'h0;
         wel_q <= 1'b0;
         is_wae_q <= 1'b0;
         erase_error <= 1'b0;
         erase_start <= 1'b0;
         erase_addr <= 32'h0;
         erase_len <= 32'h0;
         sus_cnt_q <= 32'h0;
      end else begin
         erase_start <= 1'b0;
         if (state_q == SFES_RUN || state_q == SFES_SUSPENDING) begin
            timer_q <= timer_q + 32'h1;
         end
         case (state_q)
            SFES_IDLE: begin
               if (frame_done && done_op_q == OP_WRITE_ENABLE && done_bits_q == 6'(OP_BITS)) begin
                  wel_q <= 1'b1;
               end else if (frame_done && wel_q && (is_pse || is_se)
                            && done_bits_q == 6'(OP_BITS) + addr_bits) begin
                  wel_q <= 1'b0;
                  if (is_pse && uniform_large_sectors) begin
                     wel_q <= 1'b1;
                  end else if (target_protected || block_protect_bits != 3'h0
                               || (is_se && range_has_protected)) begin
                     erase_error <= 1'b1;
                  end else if (is_pse && !target_is_small) begin
                     erase_error <= erase_error;
                  end else begin
                     state_q <= SFES_RUN;
                     is_wae_q <= 1'b0;
                     timer_q <= 32'h0;
                     erase_cyc_q <= is_pse ? 32'(PSE_CYC) : 32'(SE_CYC);
                     erase_addr <= (addr_bits == 6'(ADDR4_BITS)) ? addr_q : {8'h0, addr_q[23:0]};
                     erase_len <= is_pse ? 32'h1000 : (sector_size_256k ? 32'h40000 : 32'h10000);
                     erase_start <= 1'b1;
                  end
               end else if (frame_done && wel_q && (done_op_q == OP_WAE_A || done_op_q == OP_WAE_B)
                            && done_bits_q == 6'(OP_BITS)) begin
                  wel_q <= 1'b0;
                  if (block_protect_bits == 3'h0) begin
                     state_q <= SFES_RUN;
                     is_wae_q <= 1'b1;
                     timer_q <= 32'h0;
                     erase_cyc_q <= 32'(WAE_CYC);
                     erase_addr <= 32'h0;
                     erase_len <= 32'h0;
                     erase_start <= 1'b1;
                  end
               end
            end
            SFES_RUN: begin
               if (timer_q >= erase_cyc_q) begin
                  state_q <= SFES_IDLE;
               end else if (frame_done && done_op_q == OP_SUSPEND && !is_wae_q) begin
                  state_q <= SFES_SUSPENDING;
                  sus_cnt_q <= 32'h0;
               end
            end
            SFES_SUSPENDING: begin
               sus_cnt_q <= sus_cnt_q + 32'h1;
               if (timer_q >= erase_cyc_q) begin
                  state_q <= SFES_IDLE;
               end else if (sus_cnt_q >= 32'(SUS_CYC - 1)) begin
                  state_q <= SFES_SUSPENDED;
               end
            end
            SFES_SUSPENDED: begin
               if (frame_done && done_op_q == OP_WRITE_ENABLE && done_bits_q == 6'(OP_BITS)) begin
                  wel_q <= 1'b1;
               end else if (frame_done && done_op_q == OP_RESUME) begin
                  state_q <= SFES_RUN;
               end
            end
            default: state_q <= SFES_IDLE;
         endcase
      end
   end
   // Status shift-out for the two status read commands.
   always_comb begin
      status_q = 8'h0;
      if (op_q == OP_STATUS_ONE) begin
         status_q[SR1_WIP] = work_in_progress_flag;
         status_q[SR1_WEL] = wel_q;
         status_q[SR1_EERR] = erase_error;
      end else if (op_q == OP_STATUS_TWO) begin
         status_q[SR2_ESUS] = erase_suspended;
      end
   end
   always_ff @(negedge link.sck or negedge rstn) begin
      if (!rstn) begin
         link.so <= 1'b0;
      end else if (bit_cnt_q >= 6'(OP_BITS)) begin
         link.so <= status_q[3'(7 - ((bit_cnt_q - 6'(OP_BITS)) & 6'h7))];
      end else begin
         link.so <= 1'b0;
      end
   end
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         work_in_progress_flag <= 1'b0;
         erase_suspended <= 1'b0;
      end else begin
         work_in_progress_flag <= (state_q == SFES_RUN || state_q == SFES_SUSPENDING);
         erase_suspended <= (state_q == SFES_SUSPENDED);
      end
   end
endmodule : sfes_device
`default_nettype wire

// >>> verilog/sfes_host.sv
// Host controller that sends one command frame and can poll status.
`timescale 1ns/1ps
`default_nettype none
module sfes_host #(
   parameter int DIV = sfes_pkg::HOST_DIV
) (
   input wire logic clk,
   input wire logic rstn,
   sfes_link_if.host link,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_op,
   input wire logic [31:0] cmd_addr,
   input wire logic [5:0] cmd_addr_bits,
   output logic cmd_busy,
   output logic [7:0] status_byte,
   output logic status_valid
);
   import sfes_pkg::*;
   logic [7:0] div_q;
   logic [39:0] sh_q;
   logic [6:0] left_q;
   logic [7:0] rx_q;
   logic so_s1_q;
   logic so_s2_q;
   logic is_read_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         so_s1_q <= 1'b0;
         so_s2_q <= 1'b0;
      end else begin
         so_s1_q <= link.so;
         so_s2_q <= so_s1_q;
      end
   end
   // Frame ends exactly after the last address bit, or after the status byte for the two status read commands.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 8'h0;
         sh_q <= 40'h0;
         left_q <= 7'h0;
         link.sck <= 1'b0;
         link.cs_n <= 1'b1;
         link.si <= 1'b0;
         cmd_busy <= 1'b0;
         rx_q <= 8'h0;
         status_byte <= 8'h0;
         status_valid <= 1'b0;
         is_read_q <= 1'b0;
      end else begin
         status_valid <= 1'b0;
         if (!cmd_busy) begin
            if (cmd_valid) begin
               cmd_busy <= 1'b1;
               link.cs_n <= 1'b0;
               is_read_q <= (cmd_op == OP_STATUS_ONE) || (cmd_op == OP_STATUS_TWO);
               sh_q <= {cmd_op, cmd_addr << (6'd32 - cmd_addr_bits)};
               left_q <= ((cmd_op == OP_STATUS_ONE) || (cmd_op == OP_STATUS_TWO))
                  ? 7'd16 : 7'(OP_BITS) + 7'(cmd_addr_bits);
               link.si <= cmd_op[7];
               div_q <= 8'h0;
            end
         end else if (div_q == 8'(DIV - 1)) begin
            div_q <= 8'h0;
            if (!link.sck) begin
               if (left_q == 7'h0) begin
                  link.cs_n <= 1'b1;
                  cmd_busy <= 1'b0;
                  if (is_read_q) begin
                     status_byte <= rx_q;
                     status_valid <= 1'b1;
                  end
               end else begin
                  link.sck <= 1'b1;
                  rx_q <= {rx_q[6:0], so_s2_q};
                  left_q <= left_q - 7'h1;
               end
            end else begin
               link.sck <= 1'b0;
               sh_q <= {sh_q[38:0], 1'b0};
               link.si <= sh_q[38];
            end
         end else begin
            div_q <= div_q + 8'h1;
         end
      end
   end
endmodule : sfes_host
`default_nettype wire

// >>> verilog/sfes_link_if.sv
// Serial link between the host controller and the flash erase sequencer.
`timescale 1ns/1ps
`default_nettype none
interface sfes_link_if;
   logic sck;
   logic cs_n;
   logic si;
   logic so;
   modport dev (input sck, input cs_n, input si, output so);
   modport host (output sck, output cs_n, output si, input so);
endinterface : sfes_link_if
`default_nettype wire

// >>> verilog/sfes_pkg.sv
// Shared opcodes, status bit positions and timing counts for the erase sequencer.
package sfes_pkg;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_PSE = 8'h20;
   localparam logic [7:0] OP_PSE_WIDE = 8'h21;
   localparam logic [7:0] OP_SE = 8'hd8;
   localparam logic [7:0] OP_SE_WIDE = 8'hdc;
   localparam logic [7:0] OP_WAE_A = 8'h60;
   localparam logic [7:0] OP_WAE_B = 8'hc7;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_STATUS_ONE = 8'h05;
   localparam logic [7:0] OP_STATUS_TWO = 8'h07;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int SR1_WIP = 0;
   localparam int SR1_WEL = 1;
   localparam int SR1_EERR = 5;
   localparam int SR2_ESUS = 1;
   localparam int PSE_CYCLES = 64;
   localparam int SE_CYCLES = 256;
   localparam int WAE_CYCLES = 1024;
   localparam int SUSPEND_CYCLES = 8;
   localparam int HOST_DIV = 4;
   localparam int OP_BITS = 8;
   localparam int ADDR3_BITS = 24;
   localparam int ADDR4_BITS = 32;
endpackage : sfes_pkg
